// >>> smem_pkg.sv
// Purpose: Shared constants and types of the static memory mode block.
// Assumes: Registers on APB, one aligned 32-bit word each.
// Notes:   Strobe timing counts are fixed here; timing registers live
//          elsewhere.
package smem_pkg;
    // Chip selects served and their index width
    localparam int NUM_CS = 2;
    localparam int CS_W   = 1;
    localparam int ADDR_W = 24;

    // Register map
    localparam logic [7:0]  MODE_OFF   = 8'h0c;
    localparam logic [7:0]  CS_STRIDE  = 8'h10;
    localparam logic [7:0]  STATUS_OFF = 8'h40;
    localparam logic [31:0] MODE_RESET = 32'h1000_2103;
    localparam logic [31:0] MODE_WMASK = 32'h311f_3133;

    // Status word field positions
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_PAGE_BIT  = 1;
    localparam int STAT_FLOAT_LSB = 8;
    localparam int STAT_STATE_LSB = 16;

    // Access phase lengths in clock cycles
    localparam logic [3:0] SETUP_CYC      = 4'h1;
    localparam logic [3:0] PULSE_CYC      = 4'h3;
    localparam logic [3:0] PAGE_PULSE_CYC = 4'h2;
    localparam logic [3:0] HOLD_CYC       = 4'h1;

    // Smallest page is four bytes, so two address bits stay in a page
    localparam logic [2:0] PAGE_LSB_BASE = 3'h2;

    // Field encodings
    localparam logic [1:0] BUS_W8      = 2'h0;
    localparam logic [1:0] BUS_W16     = 2'h1;
    localparam logic [1:0] WAIT_OFF    = 2'h0;
    localparam logic [1:0] WAIT_FROZEN = 2'h2;
    localparam logic [1:0] WAIT_READY  = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_PULSE = 2'b10,
        ST_HOLD  = 2'b11
    } acc_state_e;

    // Mode register laid out bit for bit
    typedef struct packed {
        logic [1:0] rsv31;
        logic [1:0] page_size_sel;
        logic [2:0] rsv27;
        logic       page_read_en;
        logic [2:0] rsv23;
        logic       float_optimize_en;
        logic [3:0] float_cycles;
        logic [1:0] rsv15;
        logic [1:0] bus_width_sel;
        logic [2:0] rsv11;
        logic       byte_access_type;
        logic [1:0] rsv7;
        logic [1:0] wait_mode_sel;
        logic [1:0] rsv3;
        logic       write_ctrl_sel;
        logic       read_ctrl_sel;
    } mode_s;

    // One access request from the on-chip side
    typedef struct packed {
        logic              write;
        logic [CS_W-1:0]   cs;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       wdata;
        logic [1:0]        be;
    } req_s;
endpackage

// >>> static_mem_ctrl.sv
// Purpose: Per chip select mode registers and the access sequencer they
//          steer: page reads, data float, bus width, byte strobes, wait.
// Assumes: CLK at 20 MHz; external wait and data pins are asynchronous.
// Notes:   Strobe pins decode the registered state, so they may glitch
//          on state changes; data and address come from flip-flops.
`timescale 1ns/1ns
module static_mem_ctrl (
    input  wire logic                                CLK,
    input  wire logic                                RESET_N,
    input  wire logic                                PSEL,
    input  wire logic                                PENABLE,
    input  wire logic                                PWRITE,
    input  wire logic [7:0]                          PADDR,
    input  wire logic [31:0]                         PWDATA,
    output logic [31:0]                              PRDATA,
    output logic                                     PREADY,
    output logic                                     PSLVERR,
    input  wire smem_pkg::req_s                      REQ,
    input  wire logic                                REQ_VALID,
    output logic                                     REQ_READY,
    output logic                                     RSP_VALID,
    output logic [15:0]                              RSP_RDATA,
    output logic [smem_pkg::NUM_CS-1:0]              CHIP_SEL_N,
    output logic                                     READ_STROBE_N,
    output logic                                     WRITE_STROBE_N,
    output logic                                     BYTE_SEL0_N,
    output logic                                     BYTE_SEL1_N,
    output logic                                     BYTE_WRITE_STROBE0_N,
    output logic                                     BYTE_WRITE_STROBE1_N,
    output logic [smem_pkg::ADDR_W-1:0]              MEM_ADDR,
    output logic [15:0]                              DATA_OUT,
    output logic                                     DATA_OE,
    input  wire logic [15:0]                         DATA_IN,
    input  wire logic                                EXT_WAIT_N
);
    smem_pkg::mode_s            mode_r [smem_pkg::NUM_CS];
    smem_pkg::acc_state_e       state_r;
    smem_pkg::req_s             cur_r;
    smem_pkg::mode_s            cur_mode;
    smem_pkg::mode_s            req_mode;
    logic [3:0]                 cnt_r;
    logic [4:0]                 float_cnt_r;
    logic [smem_pkg::CS_W-1:0]  float_cs_r;
    logic                       page_valid_r;
    logic [smem_pkg::CS_W-1:0]  page_cs_r;
    logic [smem_pkg::ADDR_W-1:0] page_addr_r;
    logic                       wait_s1_r;
    logic                       wait_s2_r;
    logic [15:0]                data_s1_r;
    logic [15:0]                data_s2_r;
    logic [15:0]                rdata_r;
    logic                       rsp_valid_r;
    logic [31:0]                prdata_r;
    logic                       mode_hit;
    logic [smem_pkg::CS_W-1:0]  mode_sel;
    logic                       status_hit;
    logic [31:0]                status_word;
    logic                       wait_low;
    logic                       frozen;
    logic                       not_ready;
    logic                       pulse_end;
    logic                       float_hold;
    logic                       req_blocked;
    logic                       page_hit;
    logic                       accept;
    logic                       ctrl_is_cs;
    logic                       in_acc;
    logic                       wide;
    logic                       byte_write_mode;
    logic                       strobe_on;
    logic                       cs_on;

    // Byte address of one chip select's mode register
    function automatic logic [7:0] mode_addr(input int idx);
        return 8'(smem_pkg::MODE_OFF + smem_pkg::CS_STRIDE * idx);
    endfunction

    // Same page when address bits above the page offset agree
    function automatic logic page_match(
        input logic [smem_pkg::ADDR_W-1:0] a,
        input logic [smem_pkg::ADDR_W-1:0] b,
        input logic [1:0]                  psz
    );
        logic [2:0] sh;
        sh = {1'b0, psz} + smem_pkg::PAGE_LSB_BASE;
        return (a >> sh) == (b >> sh);
    endfunction

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wait_s1_r <= 1'b1;
            wait_s2_r <= 1'b1;
            data_s1_r <= 16'h0000;
            data_s2_r <= 16'h0000;
        end else begin
            wait_s1_r <= EXT_WAIT_N;
            wait_s2_r <= wait_s1_r;
            data_s1_r <= DATA_IN;
            data_s2_r <= data_s1_r;
        end
    end

    // APB address decode
    always_comb begin
        mode_hit = 1'b0;
        mode_sel = '0;
        for (int i = 0; i < smem_pkg::NUM_CS; i++) begin
            if (PADDR == mode_addr(i)) begin
                mode_hit = 1'b1;
                mode_sel = smem_pkg::CS_W'(i);
            end
        end
        status_hit = (PADDR == smem_pkg::STATUS_OFF);
    end

    // Mode registers; reserved bits never store, so they read zero
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < smem_pkg::NUM_CS; i++) begin
                mode_r[i] <= smem_pkg::MODE_RESET;
            end
        end else if (PSEL && PENABLE && PWRITE && mode_hit) begin
            mode_r[mode_sel] <= PWDATA & smem_pkg::MODE_WMASK;
        end
    end

    // Status: live view of the sequencer
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[smem_pkg::STAT_BUSY_BIT] = (state_r != smem_pkg::ST_IDLE);
        status_word[smem_pkg::STAT_PAGE_BIT] = page_valid_r;
        status_word[smem_pkg::STAT_FLOAT_LSB +: 5] = float_cnt_r;
        status_word[smem_pkg::STAT_STATE_LSB +: 2] = state_r;
    end

    // Read data is captured in the setup phase so it leaves a flop
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_r <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            if (mode_hit) begin
                prdata_r <= mode_r[mode_sel];
            end else if (status_hit) begin
                prdata_r <= status_word;
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    assign PRDATA  = prdata_r;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(mode_hit || status_hit);

    // Decode of the current access and the wait input
    assign cur_mode  = mode_r[cur_r.cs];
    assign req_mode  = mode_r[REQ.cs];
    assign wait_low  = !wait_s2_r;
    assign frozen    = (state_r == smem_pkg::ST_PULSE) && wait_low
                    && (cur_mode.wait_mode_sel == smem_pkg::WAIT_FROZEN);
    assign not_ready = wait_low
                    && (cur_mode.wait_mode_sel == smem_pkg::WAIT_READY);
    assign pulse_end = (state_r == smem_pkg::ST_PULSE) && (cnt_r <= 4'h1)
                    && !frozen && !not_ready;
    // Float only guards the bus against a different driver
    assign float_hold = (float_cnt_r != 5'h00)
                     && ((cur_r.cs != float_cs_r) || cur_r.write);
    assign req_blocked = (float_cnt_r != 5'h00)
                      && ((REQ.cs != float_cs_r) || REQ.write);
    assign page_hit = page_valid_r && !REQ.write && (REQ.cs == page_cs_r)
                   && req_mode.page_read_en
                   && page_match(REQ.addr, page_addr_r,
                                 req_mode.page_size_sel);
    // Optimised modes may start setup while the float runs down
    assign REQ_READY = (state_r == smem_pkg::ST_IDLE)
                    && (!req_blocked || req_mode.float_optimize_en);
    assign accept = REQ_VALID && REQ_READY;

    // Access sequencer
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= smem_pkg::ST_IDLE;
            cnt_r   <= 4'h0;
            cur_r   <= '0;
        end else begin
            unique case (state_r)
                smem_pkg::ST_IDLE: begin
                    if (accept) begin
                        cur_r <= REQ;
                        if (page_hit) begin
                            state_r <= smem_pkg::ST_PULSE;
                            cnt_r   <= smem_pkg::PAGE_PULSE_CYC;
                        end else begin
                            state_r <= smem_pkg::ST_SETUP;
                            cnt_r   <= smem_pkg::SETUP_CYC;
                        end
                    end
                end
                smem_pkg::ST_SETUP: begin
                    if (cnt_r > 4'h1) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (!float_hold) begin
                        // Float wait lands after the setup here
                        state_r <= smem_pkg::ST_PULSE;
                        cnt_r   <= smem_pkg::PULSE_CYC;
                    end
                end
                smem_pkg::ST_PULSE: begin
                    if (frozen) begin
                        cnt_r <= cnt_r;
                    end else if (cnt_r > 4'h1) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (pulse_end) begin
                        state_r <= smem_pkg::ST_HOLD;
                        cnt_r   <= smem_pkg::HOLD_CYC;
                    end
                end
                smem_pkg::ST_HOLD: begin
                    if (cnt_r > 4'h1) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        state_r <= smem_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Float counter starts when the read's controlling signal rises
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            float_cnt_r <= 5'h00;
            float_cs_r  <= '0;
        end else if (pulse_end && !cur_r.write) begin
            float_cnt_r <= {1'b0, cur_mode.float_cycles} + 5'h01;
            float_cs_r  <= cur_r.cs;
        end else if (float_cnt_r != 5'h00) begin
            float_cnt_r <= float_cnt_r - 5'h01;
        end
    end

    // Open page tracking; an idle gap drops the chip select and the page
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            page_valid_r <= 1'b0;
            page_cs_r    <= '0;
            page_addr_r  <= '0;
        end else if (accept) begin
            page_valid_r <= !REQ.write && req_mode.page_read_en;
            page_cs_r    <= REQ.cs;
            page_addr_r  <= REQ.addr;
        end else if (state_r == smem_pkg::ST_IDLE && !REQ_VALID) begin
            page_valid_r <= 1'b0;
        end
    end

    // Read data and the answer pulse
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r     <= 16'h0000;
            rsp_valid_r <= 1'b0;
        end else begin
            if (pulse_end && !cur_r.write) begin
                rdata_r <= wide ? data_s2_r : {8'h00, data_s2_r[7:0]};
            end
            rsp_valid_r <= (state_r == smem_pkg::ST_HOLD)
                        && (cnt_r <= 4'h1);
        end
    end

    assign RSP_VALID = rsp_valid_r;
    assign RSP_RDATA = rdata_r;

    // Which signal times the access, and the byte lane scheme
    assign ctrl_is_cs = cur_r.write ? !cur_mode.write_ctrl_sel
                                    : !cur_mode.read_ctrl_sel;
    assign in_acc = (state_r != smem_pkg::ST_IDLE);
    assign wide   = (cur_mode.bus_width_sel == smem_pkg::BUS_W16);
    assign byte_write_mode = wide && cur_mode.byte_access_type;
    assign strobe_on = ctrl_is_cs ? in_acc
                                  : (state_r == smem_pkg::ST_PULSE);
    assign cs_on     = ctrl_is_cs ? (state_r == smem_pkg::ST_PULSE)
                                  : in_acc;

    // Chip selects; an open page keeps its select low between reads
    always_comb begin
        for (int i = 0; i < smem_pkg::NUM_CS; i++) begin
            CHIP_SEL_N[i] = !((in_acc && cs_on
                               && cur_r.cs == smem_pkg::CS_W'(i))
                            || (!in_acc && page_valid_r
                               && page_cs_r == smem_pkg::CS_W'(i)));
        end
    end

    // Strobes and byte lanes
    assign READ_STROBE_N  = !(strobe_on && !cur_r.write);
    assign WRITE_STROBE_N = !(strobe_on && cur_r.write
                            && !byte_write_mode);
    assign BYTE_WRITE_STROBE0_N = !(strobe_on && cur_r.write
                                  && byte_write_mode && cur_r.be[0]);
    assign BYTE_WRITE_STROBE1_N = !(strobe_on && cur_r.write
                                  && byte_write_mode && cur_r.be[1]);
    assign BYTE_SEL0_N = !(in_acc && wide && !cur_mode.byte_access_type
                         && cur_r.be[0]);
    assign BYTE_SEL1_N = !(in_acc && wide && !cur_mode.byte_access_type
                         && cur_r.be[1]);
    assign MEM_ADDR = cur_r.addr;
    assign DATA_OUT = cur_r.wdata;
    assign DATA_OE  = cur_r.write && (state_r == smem_pkg::ST_PULSE
                                   || state_r == smem_pkg::ST_HOLD);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_page_hit_pulse: assert property (
        (accept && page_hit) |=> (state_r == smem_pkg::ST_PULSE)
            && (cnt_r == smem_pkg::PAGE_PULSE_CYC))
        else $error("page hit did not skip setup");
    a_single_read_setup: assert property (
        (accept && !REQ.write && !req_mode.page_read_en)
            |=> (state_r == smem_pkg::ST_SETUP))
        else $error("single read did not start with setup");
    a_page_miss_setup: assert property (
        (accept && !REQ.write && page_valid_r && REQ.cs == page_cs_r
            && !page_match(REQ.addr, page_addr_r, req_mode.page_size_sel))
            |=> (state_r == smem_pkg::ST_SETUP))
        else $error("page break not taken");
    a_float_count_load: assert property (
        (pulse_end && !cur_r.write)
            |=> float_cnt_r == {1'b0, $past(cur_mode.float_cycles)} + 5'h01)
        else $error("float count not float cycles plus one");
    a_float_blocks_bus: assert property (
        (float_cnt_r != 5'h00 && REQ.cs != float_cs_r
            && !req_mode.float_optimize_en) |-> !REQ_READY)
        else $error("other chip select let on during float");
    a_opt_holds_setup: assert property (
        (state_r == smem_pkg::ST_SETUP && float_cnt_r > 5'h01
            && cur_r.cs != float_cs_r)
            |=> (state_r == smem_pkg::ST_SETUP) [*1] ##1 1'b1)
        else $error("strobe pulse began during float");
    a_wait_frozen: assert property (
        frozen |=> (state_r == smem_pkg::ST_PULSE) && $stable(cnt_r))
        else $error("frozen wait did not stop the pulse");
    a_wait_ready: assert property (
        (state_r == smem_pkg::ST_PULSE && cnt_r == 4'h1 && not_ready)
            |=> state_r == smem_pkg::ST_PULSE)
        else $error("ready wait did not extend the pulse");
    a_wait_ignored: assert property (
        (state_r == smem_pkg::ST_PULSE && cnt_r == 4'h1
            && cur_mode.wait_mode_sel == smem_pkg::WAIT_OFF)
            |=> state_r == smem_pkg::ST_HOLD)
        else $error("disabled wait still stretched the pulse");
    a_byte_write_lines: assert property (
        (in_acc && byte_write_mode) |-> WRITE_STROBE_N
            && BYTE_SEL0_N && BYTE_SEL1_N)
        else $error("byte write type drove select lines");
    a_cs_times_write: assert property (
        (state_r == smem_pkg::ST_SETUP && cur_r.write
            && !cur_mode.write_ctrl_sel) |-> (&CHIP_SEL_N))
        else $error("chip select low in write setup");
endmodule

// >>> smem_partner.sv
// Purpose: Stand-in for an async static memory on the far side.
// Assumes: Read data appear only while selected and read strobe is low.
// Notes:   Released bus shows inverted data, so stale values never match.
`timescale 1ns/1ns
module smem_partner (
    input  wire logic [smem_pkg::NUM_CS-1:0] cs_n,
    input  wire logic                        rd_n,
    input  wire logic [23:0]                 addr,
    input  wire logic                        stall,
    output logic      [15:0]                 data,
    output logic                             wait_n
);
    // Drive only in the strobe pulse; inverse elsewhere
    assign data = (&cs_n | rd_n) ? ~(addr[15:0] ^ 16'h5a3c)
                                 : addr[15:0] ^ 16'h5a3c;
    // Wait line follows the bench's stall command
    assign wait_n = ~stall;
endmodule

// >>> static_mem_cs_mode_config_tb.sv
// Purpose: Self-checking bench for the static memory mode block.
// Assumes: APB answers without wait states; one request at a time.
// Notes:   Latency is measured mid-cycle from take edge to response.
`timescale 1ns/1ns
module static_mem_cs_mode_config_tb;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]        padr = 8'h00;
    logic [31:0]       pwd = 32'h0, prd, rd;
    logic              prdy, perr, se, rrdy, rsv, doe, wn;
    smem_pkg::req_s    req = '0;
    logic              rv = 1'b0, stall = 1'b0;
    logic [15:0]       rsd, din, dout;
    logic [1:0]        csn;
    logic              rdn, wen, bs0, bs1, bw0, bw1;
    logic [23:0]       madr;
    logic [4:0]        seen = 5'h00;
    int                err_count = 0, num_checks = 0, cyc = 0, tk = 0;
    int                rsc = 0, gap = 0, k;
    int                lat_q[$];
    // Edges from take to answer: full access, and a page hit
    localparam int NRM = smem_pkg::SETUP_CYC + smem_pkg::PULSE_CYC
                       + smem_pkg::HOLD_CYC;
    localparam int PGL = smem_pkg::PAGE_PULSE_CYC + smem_pkg::HOLD_CYC;
    always #25 clk = ~clk;
    static_mem_ctrl dut_u (.CLK(clk), .RESET_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
        .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .REQ(req),
        .REQ_VALID(rv), .REQ_READY(rrdy), .RSP_VALID(rsv),
        .RSP_RDATA(rsd), .CHIP_SEL_N(csn), .READ_STROBE_N(rdn),
        .WRITE_STROBE_N(wen), .BYTE_SEL0_N(bs0), .BYTE_SEL1_N(bs1),
        .BYTE_WRITE_STROBE0_N(bw0), .BYTE_WRITE_STROBE1_N(bw1),
        .MEM_ADDR(madr), .DATA_OUT(dout), .DATA_OE(doe),
        .DATA_IN(din), .EXT_WAIT_N(wn));
    smem_partner mem_u (.cs_n(csn), .rd_n(rdn), .addr(madr),
        .stall(stall), .data(din), .wait_n(wn));
    always @(posedge clk) cyc <= cyc + 1;
    // Mid-cycle sampling; response logged before a new take
    always @(negedge clk) begin
        if (rsv) lat_q.push_back(cyc - tk);
        if (rv && rrdy) tk = cyc + 1;
        seen |= ~{wen, bs0, bs1, bw0, bw1};
        rsc = rdn ? rsc + 1 : 0;
        if (!csn[1] && gap < 0) gap = rsc;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer; holds until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        se = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Leaves valid high so a following call is back to back
    task automatic acc(input logic w, c, input logic [23:0] a,
                       input logic [1:0] be);
        req <= '{write: w, cs: c, addr: a, wdata: 16'hc35a, be: be};
        rv <= 1'b1;
        do @(posedge clk); while (!(rv && rrdy === 1'b1));
    endtask
    task automatic rsp(input int n);
        rv <= 1'b0;
        while (lat_q.size() < n) @(posedge clk);
    endtask
    function automatic logic [15:0] mem(input logic [23:0] a);
        return a[15:0] ^ 16'h5a3c;
    endfunction
    task automatic conclude();
        if (err_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        err_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, 8'h0c, 0);
        chk("mode0", rd, 32'h1000_2103);
        apb(1, 8'h1c, '1);
        apb(0, 8'h1c, 0);
        chk("mode1", rd, 32'h311f_3133);
        apb(0, 8'h30, 0);
        chk("slverr", se, 1);
        chk("unmapped", rd, 0);
        apb(1, 8'h1c, 32'h1003);
        // Reserved width behaves as the narrow bus
        acc(0, 0, 24'h001234, 3);
        rsp(1);
        chk("lat", lat_q[0], NRM);
        chk("rd8", rsd, mem(24'h001234) & 16'h00ff);
        apb(1, 8'h0c, 32'h1000);
        acc(0, 0, 24'h00abcd, 3);
        rsp(2);
        chk("rd16", rsd, mem(24'h00abcd));
        // Page hits shorten the access; a page break does not
        apb(1, 8'h0c, 32'h0100_1001);
        acc(0, 0, 24'h40, 3);
        acc(0, 0, 24'h42, 3);
        acc(0, 0, 24'h44, 3);
        apb(1, 8'h0c, 32'h1100_1001);
        acc(0, 0, 24'h60, 3);
        acc(0, 0, 24'h64, 3);
        rsp(7);
        chk("pg4a", lat_q[2], NRM);
        chk("pg4b", lat_q[3], PGL);
        chk("pg4c", lat_q[4], NRM);
        chk("pg8a", lat_q[5], NRM);
        chk("pg8b", lat_q[6], PGL);
        // Byte strobe schemes on the wide bus
        apb(1, 8'h0c, 32'h1103);
        seen = 5'h00;
        acc(1, 0, 24'h10, 2'b10);
        rsp(8);
        chk("bytewr", seen, 5'b00001);
        apb(1, 8'h0c, 32'h1003);
        seen = 5'h00;
        acc(1, 0, 24'h10, 2'b01);
        rsp(9);
        chk("bytesel", seen, 5'b11000);
        chk("wdata", dout, 16'hc35a);
        chk("oe_idle", doe, 1'b0);
        // Other select kept off the bus for float plus one cycles
        apb(1, 8'h0c, 32'h0003_1001);
        gap = -1;
        acc(0, 0, 24'h80, 3);
        acc(1, 1, 24'h80, 3);
        rsp(11);
        chk("float", gap >= 5, 1);
        // Stall held: ignored, frozen, ready; hold is twelve cycles past the take
        for (int m = 0; m < 4; m++) begin
            if (m != 1) begin
                apb(1, 8'h0c, 32'h1001 | (32'(m) << 4));
                stall <= 1'b1;
                k = lat_q.size();
                acc(0, 0, 24'h100, 3);
                rsp(0);
                repeat (12) @(posedge clk);
                chk("stall", lat_q.size(), k + (m == 0));
                stall <= 1'b0;
                rsp(k + 1);
            end
        end
        conclude();
    end
endmodule
